//--- design/smbext_defines.vh
// Constants for the SMBus extension block: register indices, fields, resets, timing
// Included by the top design file, the checker and the bench; definitions only
`ifndef SMBEXT_DEFINES_VH
`define SMBEXT_DEFINES_VH

// Register indices (byte address is four times the index)
`define SMBEXT_IDX_CTRL        8'h08
`define SMBEXT_IDX_ADDR2       8'h09
`define SMBEXT_IDX_LTH         8'h0a
`define SMBEXT_IDX_LTL         8'h0b
`define SMBEXT_IDX_ACK         8'h0c
`define SMBEXT_IDX_MATCH       8'h0d

// Control and status fields
`define SMBEXT_FAST_ACK        7
`define SMBEXT_ALERT_EN        6
`define SMBEXT_ADDR2_EN        5
`define SMBEXT_TCK_SEL         4
`define SMBEXT_LOW_FLAG        3
`define SMBEXT_IDLE_FLAG       2
`define SMBEXT_HDL_FLAG        1
`define SMBEXT_HDL_IE          0

// Reset values
`define SMBEXT_RST_CTRL        8'h00
`define SMBEXT_RST_ADDR2       8'hc2
`define SMBEXT_RST_LT          8'h00

// Fixed addresses and timing
`define SMBEXT_ALERT_ADDR      7'h0c
`define SMBEXT_SLOW_DIV        7'd64
`define SMBEXT_HIGH_SHIFT      9
`define SMBEXT_CLK_MHZ         100

`endif

//--- design/smbext_sync.v
// Three-stage synchroniser for one asynchronous pin; output changes when stages two and three agree
// Assumes core_clk domain, asynchronous active-low reset
`timescale 1ns/1ps
module smbext_sync (
    // Clock and reset
    input  wire core_clk,
    input  wire reset_n,
    // Pin and result
    input  wire pinIn,
    output reg  pinOut
);
    reg [2:0] stage_reg;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_reg <= 3'h7;
            pinOut    <= 1'b1;
        end else begin
            stage_reg <= {stage_reg[1:0], pinIn};
            if (stage_reg[1] == stage_reg[2]) begin
                pinOut <= stage_reg[2];
            end
        end
    end
endmodule // smbext_sync

//--- design/smbext_timer.v
// Timeout counter: counts while a condition holds, flags on the tick after the count reaches a threshold
// Assumes core_clk domain; tick is a one-cycle enable
`timescale 1ns/1ps
module smbext_timer (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset_n,
    // Control
    input  wire        tick,
    input  wire        active,
    input  wire [15:0] threshold,
    // Result
    output reg         expired
);
    reg [15:0] count_reg;

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 16'h0000;
            expired   <= 1'b0;
        end else if (!active) begin
            count_reg <= 16'h0000;
            expired   <= 1'b0;
        end else if (tick && !expired) begin
            if (count_reg >= threshold) begin
                expired <= 1'b1;
            end else begin
                count_reg <= count_reg + 16'h0001;
            end
        end
    end
endmodule // smbext_timer

//--- design/smbext_top.v
// SMBus extension: ack control, alert and second address match, SCL timeouts, AHB-Lite registers
// Assumes core_clk at 100 MHz, AHB-Lite single word transfers, bus pins asynchronous
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "smbext_defines.vh"
module smbext_top (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset_n,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Bus lines
    input  wire        sclIn,
    input  wire        sdaIn,
    // Shifter interface
    input  wire        byteReceived,
    input  wire        addrValid,
    input  wire [6:0]  addrIn,
    output reg         ackDrive,
    output reg         ackPending,
    output wire        alertMatch,
    output wire        addr2Match,
    // Interrupt
    output wire        timeoutIrq
);
    reg  [7:0]  ctrl_reg;
    reg  [7:0]  addr2_reg;
    reg  [7:0]  ltHigh_reg;
    reg  [7:0]  ltLow_reg;
    reg         txAck_reg;
    reg         fastAck_reg;
    reg  [5:0]  div_reg;
    reg         wrPend_reg;
    reg  [7:0]  wrIdx_reg;
    reg         lowFlag_reg;
    reg         hdlFlag_reg;
    reg         lowSeen_reg;
    reg         hdlSeen_reg;

    wire        sclSync;
    wire        sdaSync;
    wire        tick;
    wire        lowExpired;
    wire        idleExpired;
    wire        hdlExpired;
    wire [15:0] lowValue;
    wire [15:0] highThreshold;
    wire        lowEnable;
    wire        addrPhase;
    wire [7:0]  rdIdx;
    wire        wrCtrl;

    smbext_sync sclSyncInst (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .pinIn    (sclIn),
        .pinOut   (sclSync)
    );

    smbext_sync sdaSyncInst (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .pinIn    (sdaIn),
        .pinOut   (sdaSync)
    );

    // Value from both bytes
    assign lowValue      = {ltHigh_reg, ltLow_reg};
    assign lowEnable     = (lowValue != 16'h0000);
    assign highThreshold = lowValue >> `SMBEXT_HIGH_SHIFT;

    // Counter clock select
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_reg <= 6'h00;
        end else begin
            div_reg <= div_reg + 6'h01;
        end
    end
    assign tick = ctrl_reg[`SMBEXT_TCK_SEL] ? 1'b1 : (div_reg == 6'h3f);

    smbext_timer lowTimer (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .tick      (tick),
        .active    (lowEnable && !sclSync),
        .threshold (lowValue),
        .expired   (lowExpired)
    );

    smbext_timer idleTimer (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .tick      (tick),
        .active    (sclSync && sdaSync),
        .threshold (highThreshold),
        .expired   (idleExpired)
    );

    smbext_timer hdlTimer (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .tick      (tick),
        .active    (sclSync && !sdaSync),
        .threshold (highThreshold),
        .expired   (hdlExpired)
    );

    // AHB-Lite: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addrPhase = hsel && hready && htrans[1];
    assign rdIdx     = haddr[9:2];
    assign wrCtrl    = wrPend_reg && (wrIdx_reg == `SMBEXT_IDX_CTRL);

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPend_reg <= 1'b0;
            wrIdx_reg  <= 8'h00;
            hrdata     <= 32'h00000000;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            if (addrPhase) begin
                wrIdx_reg <= rdIdx;
            end
            if (addrPhase && !hwrite) begin
                case (rdIdx)
                    `SMBEXT_IDX_CTRL:  hrdata <= {24'h000000, ctrl_reg[7:4], lowFlag_reg,
                                                  idleExpired, hdlFlag_reg, ctrl_reg[0]};
                    `SMBEXT_IDX_ADDR2: hrdata <= {24'h000000, addr2_reg[7:1], 1'b0};
                    `SMBEXT_IDX_LTH:   hrdata <= {24'h000000, ltHigh_reg};
                    `SMBEXT_IDX_LTL:   hrdata <= {24'h000000, ltLow_reg};
                    `SMBEXT_IDX_ACK:   hrdata <= {30'h00000000, ackPending, txAck_reg};
                    `SMBEXT_IDX_MATCH: hrdata <= {30'h00000000, alertMatch, addr2Match};
                    default:           hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Registers written by software
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg   <= `SMBEXT_RST_CTRL;
            addr2_reg  <= `SMBEXT_RST_ADDR2;
            ltHigh_reg <= `SMBEXT_RST_LT;
            ltLow_reg  <= `SMBEXT_RST_LT;
        end else if (wrPend_reg) begin
            case (wrIdx_reg)
                `SMBEXT_IDX_CTRL:  ctrl_reg   <= hwdata[7:0];
                `SMBEXT_IDX_ADDR2: addr2_reg  <= {hwdata[7:1], 1'b0};
                `SMBEXT_IDX_LTH:   ltHigh_reg <= hwdata[7:0];
                `SMBEXT_IDX_LTL:   ltLow_reg  <= hwdata[7:0];
                default:           ctrl_reg   <= ctrl_reg;
            endcase
        end
    end

    // Sticky flags, set beats write-one clear
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowFlag_reg <= 1'b0;
            hdlFlag_reg <= 1'b0;
            lowSeen_reg <= 1'b0;
            hdlSeen_reg <= 1'b0;
        end else begin
            lowSeen_reg <= lowExpired;
            hdlSeen_reg <= hdlExpired;
            if (lowExpired && !lowSeen_reg) begin
                lowFlag_reg <= 1'b1;
            end else if (wrCtrl && hwdata[`SMBEXT_LOW_FLAG]) begin
                lowFlag_reg <= 1'b0;
            end
            if (hdlExpired && !hdlSeen_reg) begin
                hdlFlag_reg <= 1'b1;
            end else if (wrCtrl && hwdata[`SMBEXT_HDL_FLAG]) begin
                hdlFlag_reg <= 1'b0;
            end
        end
    end

    assign timeoutIrq = hdlFlag_reg && ctrl_reg[`SMBEXT_HDL_IE];

    // Acknowledge control
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            txAck_reg   <= 1'b0;
            fastAck_reg <= 1'b0;
            ackDrive    <= 1'b0;
            ackPending  <= 1'b0;
        end else begin
            fastAck_reg <= ctrl_reg[`SMBEXT_FAST_ACK];
            if (wrPend_reg && wrIdx_reg == `SMBEXT_IDX_ACK) begin
                txAck_reg <= hwdata[0];
            end
            if (!fastAck_reg) begin
                ackPending <= 1'b0;
                if (byteReceived) begin
                    ackDrive <= !txAck_reg;
                end
            end else if (byteReceived) begin
                ackPending <= 1'b1;
            end else if (ackPending && wrPend_reg && wrIdx_reg == `SMBEXT_IDX_ACK) begin
                ackDrive   <= !hwdata[0];
                ackPending <= 1'b0;
            end
        end
    end

    // Address comparisons
    assign alertMatch = addrValid && ctrl_reg[`SMBEXT_ALERT_EN] && (addrIn == `SMBEXT_ALERT_ADDR);
    assign addr2Match = addrValid && ctrl_reg[`SMBEXT_ADDR2_EN] && (addrIn == addr2_reg[7:1]);
endmodule // smbext_top

//--- tb/smbext_line_model.sv
// Two-wire bus partner: open-drain lines with pull-ups
// Assumes the bench requests low levels; released lines float high
`timescale 1ns/1ps
module smbext_line_model (
    // Pull-low requests
    input  wire sclLow,
    input  wire sdaLow,
    // Line levels
    output wire sclIn,
    output wire sdaIn
);
    assign sclIn = !sclLow;
    assign sdaIn = !sdaLow;
endmodule // smbext_line_model

//--- tb/smbext_sva.sv
// Port checks for the SMBus extension top
// Assumes one core_clk domain and single-word AHB-Lite transfers
`timescale 1ns/1ps
`include "smbext_defines.vh"
module smbext_sva (
    // Clock and reset
    input wire        core_clk,
    input wire        reset_n,
    // Register bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    // Shifter side and interrupt
    input wire        byteReceived,
    input wire        addrValid,
    input wire [6:0]  addrIn,
    input wire        ackDrive,
    input wire        ackPending,
    input wire        alertMatch,
    input wire        addr2Match,
    input wire        timeoutIrq
);
    logic       wrPh;
    logic [7:0] wrIdx;
    logic [7:0] ctl;
    wire        rdReq = hsel && hready && htrans[1] && !hwrite;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Shadow of control writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPh <= 1'b0;
            wrIdx <= 8'h00;
            ctl <= 8'h00;
        end else begin
            wrPh <= hsel && hready && htrans[1] && hwrite;
            wrIdx <= haddr[9:2];
            if (wrPh && wrIdx == `SMBEXT_IDX_CTRL)
                ctl <= hwdata[7:0];
        end
    end
    a_zero_wait: assert property (hreadyout) else $error("wait state inserted");
    a_resp_okay: assert property (!hresp) else $error("error response given");
    a_addr2_lsb: assert property (
        rdReq && haddr[9:2] == `SMBEXT_IDX_ADDR2 |=> hrdata[0] == 1'b0) else $error("address bit zero set");
    a_unmapped_zero: assert property (rdReq && haddr == 32'h0 |=> hrdata == 32'h0) else $error("unmapped nonzero");
    a_alert_gate: assert property (
        !ctl[6] && !$past(ctl[6]) |-> !alertMatch) else $error("alert match while disabled");
    a_addr2_gate: assert property (
        !ctl[5] && !$past(ctl[5]) |-> !addr2Match) else $error("second match while disabled");
    a_irq_gate: assert property (
        !ctl[0] && !$past(ctl[0]) |-> !timeoutIrq) else $error("interrupt while disabled");
    a_pend_cause: assert property (
        $rose(ackPending) |-> $past(byteReceived) && $past(ctl[7])) else $error("pending without byte");
    a_ack_cause: assert property (
        $changed(ackDrive) && !$past(ctl[7]) |-> $past(byteReceived)) else $error("ack changed without byte");
    cover property (ackPending);
    cover property (timeoutIrq);
    cover property (addrValid && alertMatch);
    cover property (addrValid && addr2Match);
endmodule // smbext_sva

bind smbext_top smbext_sva chk_u (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .byteReceived(byteReceived), .addrValid(addrValid), .addrIn(addrIn),
    .ackDrive(ackDrive), .ackPending(ackPending), .alertMatch(alertMatch), .addr2Match(addr2Match),
    .timeoutIrq(timeoutIrq));

//--- tb/smbus_timeout_and_address_ext_tb.sv
// Self-checking bench for the SMBus extension block
// Assumes an AHB-Lite master in the bench and the line model on the pins
`timescale 1ns/1ps
`include "smbext_defines.vh"
module smbus_timeout_and_address_ext_tb;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        byteReceived = 1'b0;
    logic        addrValid = 1'b0;
    logic [6:0]  addrIn = 7'h00;
    logic        sclLow = 1'b0;
    logic        sdaLow = 1'b0;
    logic [7:0]  q;
    wire         hreadyout, hresp, sclIn, sdaIn, ackDrive, ackPending, alertMatch, addr2Match, timeoutIrq;
    wire [31:0]  hrdata;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    always #5 core_clk = ~core_clk;
    smbext_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sclIn(sclIn), .sdaIn(sdaIn), .byteReceived(byteReceived),
        .addrValid(addrValid), .addrIn(addrIn), .ackDrive(ackDrive), .ackPending(ackPending),
        .alertMatch(alertMatch), .addr2Match(addr2Match), .timeoutIrq(timeoutIrq));
    smbext_line_model line_u (.sclLow(sclLow), .sdaLow(sdaLow), .sclIn(sclIn), .sdaIn(sdaIn));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata[7:0];
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00);
        chk(q & m, e);
    endtask
    task automatic pulse;
        @(posedge core_clk);
        byteReceived <= 1'b1;
        @(posedge core_clk);
        byteReceived <= 1'b0;
        wt(2);
    endtask
    task conclude;
        $display("mismatches %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 10000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        wt(3);
        reset_n <= 1'b1;
        rd(`SMBEXT_IDX_CTRL, 8'hfb, 8'h00);
        rd(`SMBEXT_IDX_ADDR2, 8'hff, 8'hc2);
        rd(8'h00, 8'hff, 8'h00);
        xfer(1'b1, `SMBEXT_IDX_ADDR2, 8'hff);
        rd(`SMBEXT_IDX_ADDR2, 8'hff, 8'hfe);
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h10);
        sclLow <= 1'b1;
        wt(300);
        rd(`SMBEXT_IDX_CTRL, 8'h08, 8'h00);
        sclLow <= 1'b0;
        xfer(1'b1, `SMBEXT_IDX_LTL, 8'h20);
        xfer(1'b1, `SMBEXT_IDX_LTH, 8'h01);
        rd(`SMBEXT_IDX_LTH, 8'hff, 8'h01);
        rd(`SMBEXT_IDX_LTL, 8'hff, 8'h20);
        sclLow <= 1'b1;
        wt(200);
        sclLow <= 1'b0;
        wt(10);
        sclLow <= 1'b1;
        wt(200);
        rd(`SMBEXT_IDX_CTRL, 8'h08, 8'h00);
        wt(120);
        rd(`SMBEXT_IDX_CTRL, 8'h08, 8'h08);
        sclLow <= 1'b0;
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h18);
        rd(`SMBEXT_IDX_CTRL, 8'h08, 8'h00);
        xfer(1'b1, `SMBEXT_IDX_LTH, 8'h00);
        xfer(1'b1, `SMBEXT_IDX_LTL, 8'h02);
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h00);
        sclLow <= 1'b1;
        wt(100);
        rd(`SMBEXT_IDX_CTRL, 8'h08, 8'h00);
        wt(220);
        rd(`SMBEXT_IDX_CTRL, 8'h08, 8'h08);
        sclLow <= 1'b0;
        xfer(1'b1, `SMBEXT_IDX_LTL, 8'h00);
        xfer(1'b1, `SMBEXT_IDX_LTH, 8'h02);
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h18);
        wt(20);
        rd(`SMBEXT_IDX_CTRL, 8'h04, 8'h04);
        sclLow <= 1'b1;
        wt(10);
        rd(`SMBEXT_IDX_CTRL, 8'h04, 8'h00);
        sclLow <= 1'b0;
        sdaLow <= 1'b1;
        wt(20);
        rd(`SMBEXT_IDX_CTRL, 8'h02, 8'h02);
        chk({7'h0, timeoutIrq}, 8'h00);
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h11);
        chk({7'h0, timeoutIrq}, 8'h01);
        sdaLow <= 1'b0;
        wt(5);
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h13);
        rd(`SMBEXT_IDX_CTRL, 8'h02, 8'h00);
        addrValid <= 1'b1;
        addrIn <= `SMBEXT_ALERT_ADDR;
        wt(1);
        chk({7'h0, alertMatch}, 8'h00);
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h40);
        chk({7'h0, alertMatch}, 8'h01);
        addrIn <= 7'h7f;
        wt(1);
        chk({7'h0, addr2Match}, 8'h00);
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h20);
        chk({7'h0, addr2Match}, 8'h01);
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h00);
        xfer(1'b1, `SMBEXT_IDX_ACK, 8'h00);
        pulse();
        chk({7'h0, ackDrive}, 8'h01);
        xfer(1'b1, `SMBEXT_IDX_ACK, 8'h01);
        pulse();
        chk({7'h0, ackDrive}, 8'h00);
        xfer(1'b1, `SMBEXT_IDX_ACK, 8'h00);
        pulse();
        chk({7'h0, ackDrive}, 8'h01);
        xfer(1'b1, `SMBEXT_IDX_CTRL, 8'h80);
        pulse();
        chk({6'h0, ackPending, ackDrive}, 8'h03);
        xfer(1'b1, `SMBEXT_IDX_ACK, 8'h01);
        chk({6'h0, ackPending, ackDrive}, 8'h00);
        pulse();
        xfer(1'b1, `SMBEXT_IDX_ACK, 8'h00);
        chk({7'h0, ackDrive}, 8'h01);
        conclude();
    end
endmodule // smbus_timeout_and_address_ext_tb
